// ### rtl/csd_pkg.sv
// Constants for the clock source and debug clock output block.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package csd_pkg;

   // ==========================================================
   // Register indices and byte addresses (address = 4 * index)
   localparam int          IDX_DBG_CFG     = 32'h0000_1C00;
   localparam int          IDX_CPU_ST3     = 32'h0000_1C01;
   localparam int          IDX_CLK_STATUS  = 32'h0000_1C02;
   localparam int          IDX_USB_CTRL    = 32'h0000_1C03;
   localparam int          IDX_SLEW        = 32'h0000_1C16;
   localparam int          IDX_PULL_INH2   = 32'h0000_1C18;
   localparam int          AW              = 16;
   localparam logic [15:0] ADDR_DBG_CFG    = 16'(IDX_DBG_CFG * 4);
   localparam logic [15:0] ADDR_CPU_ST3    = 16'(IDX_CPU_ST3 * 4);
   localparam logic [15:0] ADDR_CLK_STATUS = 16'(IDX_CLK_STATUS * 4);
   localparam logic [15:0] ADDR_USB_CTRL   = 16'(IDX_USB_CTRL * 4);
   localparam logic [15:0] ADDR_SLEW       = 16'(IDX_SLEW * 4);
   localparam logic [15:0] ADDR_PULL_INH2  = 16'(IDX_PULL_INH2 * 4);

   // ==========================================================
   // Field positions
   localparam int          SRC_LSB         = 0;
   localparam int          SRC_W           = 2;
   localparam int          NUM_SRC         = 4;
   localparam int          DBG_OFF_BIT     = 2;
   localparam int          SLEW_BIT        = 0;
   localparam int          EXT_PD_INH_BIT  = 0;
   localparam int          USB_OSC_BIT     = 0;
   localparam int          USB_LDO_BIT     = 1;
   localparam int          ST_SEL_BIT      = 0;
   localparam int          ST_OSC_BIT      = 1;
   localparam int          ST_LDO_BIT      = 2;
   localparam int          ST_BOOT_LSB     = 3;
   localparam int          BOOT_W          = 3;

   // ==========================================================
   // Reset values and responses
   localparam logic [15:0] RST_DBG_CFG     = 16'h0000;
   localparam logic [15:0] RST_CPU_ST3     = 16'h0000;
   localparam logic [15:0] RST_SLEW        = 16'h0000;
   localparam logic [15:0] RST_PULL_INH2   = 16'h0001;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ==========================================================
   // Debug clock pin driver states
   typedef enum logic [1:0] {
      PIN_DRIVE = 2'h1,
      PIN_HIZ   = 2'h2
   } csd_pin_state_t;

endpackage : csd_pkg

// ### rtl/csd_debug_clock_pin_if.sv
// Carrier from the register logic to the debug clock pin driver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface csd_dbg_if;
   logic [1:0] source_sel;
   logic       drive_en;
   logic       slow_slew;

   modport ctrl (output source_sel, output drive_en, output slow_slew);
   modport pin  (input source_sel, input drive_en, input slow_slew);
endinterface : csd_dbg_if

// ### rtl/csd_debug_clock_pin_drv.sv
// Debug clock pin driver: source mux, output enable and pulldown.
// Assumes the generator clocks arrive synchronous to aclk.
`timescale 1ns/1ps
module csd_dbg_drv (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Control from the register logic
   csd_dbg_if.pin          cfg,
   // Internal clock-generator taps
   input  wire logic [3:0] gen_clocks,
   // Pin
   output logic            pin_out,
   output logic            pin_oe_n,
   output logic            pin_pulldown_en,
   output logic            pin_slow_slew
);

   typedef struct packed {
      csd_pkg::csd_pin_state_t st;
      logic                    out;
      logic                    slew;
   } csd_drv_state_t;

   csd_drv_state_t s;
   csd_drv_state_t next_s;
   logic [3:0]     hit;

   // ==========================================================
   // Source selection
   genvar i;
   generate
      for (i = 0; i < csd_pkg::NUM_SRC; i++) begin : g_src
         assign hit[i] = (cfg.source_sel == 2'(i)) && gen_clocks[i];
      end
   endgenerate

   // ==========================================================
   // State update
   always_comb begin
      next_s      = s;
      next_s.out  = |hit;
      next_s.slew = cfg.slow_slew;
      case (s.st)
         csd_pkg::PIN_DRIVE: begin
            if (!cfg.drive_en) next_s.st = csd_pkg::PIN_HIZ;
         end
         csd_pkg::PIN_HIZ: begin
            if (cfg.drive_en) next_s.st = csd_pkg::PIN_DRIVE;
         end
         default: next_s.st = csd_pkg::PIN_DRIVE;
      endcase
      if (!aresetn) begin
         next_s.st   = csd_pkg::PIN_DRIVE;
         next_s.out  = 1'b0;
         next_s.slew = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   // The pulldown is the complement of the driver so the pad never floats.
   assign pin_out         = s.out;
   assign pin_oe_n        = (s.st != csd_pkg::PIN_DRIVE);
   assign pin_pulldown_en = (s.st != csd_pkg::PIN_DRIVE);
   assign pin_slow_slew   = s.slew;

endmodule : csd_dbg_drv

// ### rtl/csd_clock_ctrl.sv
// Clock source selection and debug clock output control, top level.
// Assumes an AXI4-Lite master on aclk and a board strap held static.
`timescale 1ns/1ps

module csd_clock_ctrl (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [15:0] awaddr,
   input  wire logic [2:0]  awprot,
   // AXI4-Lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // AXI4-Lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [15:0] araddr,
   input  wire logic [2:0]  arprot,
   // AXI4-Lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Straps
   input  wire logic        clock_select_pin,
   input  wire logic [2:0]  boot_freq_code,
   // Clock generator
   input  wire logic [3:0]  gen_clocks,
   output logic             sys_clock_from_ext,
   output logic             ext_clock_gate_en,
   output logic             ext_clock_pulldown_en,
   output logic             usb_oscillator_enable,
   output logic             usb_regulator_enable,
   output logic [2:0]       boot_assumed_freq,
   // Debug clock pin
   output logic             debug_clock_pin_out,
   output logic             debug_clock_pin_oe_n,
   output logic             debug_clock_pin_pulldown_en,
   output logic             debug_clock_pin_slow_slew
);

   typedef struct packed {
      logic        strap_sel;
      logic [2:0]  boot_code;
      logic [15:0] dbg_cfg;
      logic [15:0] cpu_st3;
      logic [15:0] slew;
      logic [15:0] pull_inh2;
      logic        osc_en;
      logic        ldo_en;
      logic        aw_hold;
      logic [15:0] aw_addr;
      logic        w_hold;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        b_valid;
      logic [1:0]  b_resp;
      logic        r_valid;
      logic [31:0] r_data;
      logic [1:0]  r_resp;
   } csd_ctrl_state_t;

   csd_ctrl_state_t s;
   csd_ctrl_state_t next_s;
   logic [31:0]     rd_word;
   logic            rd_hit;
   logic [15:0]     status_word;

   csd_dbg_if       dbg_ctl ();

   // ==========================================================
   // Byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) res[7:0] = data[7:0];
      if (strb[1]) res[15:8] = data[15:8];
      return res;
   endfunction : merge16

   // ==========================================================
   // Read decode
   always_comb begin
      status_word                                            = 16'h0000;
      status_word[csd_pkg::ST_SEL_BIT]                       = s.strap_sel;
      status_word[csd_pkg::ST_OSC_BIT]                       = s.osc_en;
      status_word[csd_pkg::ST_LDO_BIT]                       = s.ldo_en;
      status_word[csd_pkg::ST_BOOT_LSB +: csd_pkg::BOOT_W]   = s.boot_code;
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (araddr)
         csd_pkg::ADDR_DBG_CFG:    rd_word[15:0] = s.dbg_cfg;
         csd_pkg::ADDR_CPU_ST3:    rd_word[15:0] = s.cpu_st3;
         csd_pkg::ADDR_CLK_STATUS: rd_word[15:0] = status_word;
         csd_pkg::ADDR_USB_CTRL: begin
            rd_word[csd_pkg::USB_OSC_BIT] = s.osc_en;
            rd_word[csd_pkg::USB_LDO_BIT] = s.ldo_en;
         end
         csd_pkg::ADDR_SLEW:       rd_word[15:0] = s.slew;
         csd_pkg::ADDR_PULL_INH2:  rd_word[15:0] = s.pull_inh2;
         default:                  rd_hit = 1'b0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      if (s.b_valid && bready) next_s.b_valid = 1'b0;
      if (s.r_valid && rready) next_s.r_valid = 1'b0;
      if (awvalid && awready) begin
         next_s.aw_hold = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_hold = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      // A write is carried out once address and data have both been taken.
      if (s.aw_hold && s.w_hold && !s.b_valid) begin
         next_s.aw_hold = 1'b0;
         next_s.w_hold  = 1'b0;
         next_s.b_valid = 1'b1;
         next_s.b_resp  = csd_pkg::RESP_OKAY;
         case (s.aw_addr)
            csd_pkg::ADDR_DBG_CFG:
               next_s.dbg_cfg = merge16(s.dbg_cfg, s.w_data, s.w_strb);
            csd_pkg::ADDR_CPU_ST3:
               next_s.cpu_st3 = merge16(s.cpu_st3, s.w_data, s.w_strb);
            csd_pkg::ADDR_CLK_STATUS: ;
            csd_pkg::ADDR_USB_CTRL: begin
               if (s.w_strb[0]) begin
                  next_s.osc_en = s.w_data[csd_pkg::USB_OSC_BIT];
                  next_s.ldo_en = s.w_data[csd_pkg::USB_LDO_BIT];
               end
            end
            csd_pkg::ADDR_SLEW:
               next_s.slew = merge16(s.slew, s.w_data, s.w_strb);
            csd_pkg::ADDR_PULL_INH2:
               next_s.pull_inh2 = merge16(s.pull_inh2, s.w_data, s.w_strb);
            default: next_s.b_resp = csd_pkg::RESP_SLVERR;
         endcase
      end
      if (arvalid && arready) begin
         next_s.r_valid = 1'b1;
         next_s.r_data  = rd_word;
         next_s.r_resp  = rd_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
      end
      // With the oscillator strap selected, the USB supply must never drop.
      if (!s.strap_sel) begin
         next_s.osc_en = 1'b1;
         next_s.ldo_en = 1'b1;
      end
      if (!aresetn) begin
         next_s           = '0;
         next_s.dbg_cfg   = csd_pkg::RST_DBG_CFG;
         next_s.cpu_st3   = csd_pkg::RST_CPU_ST3;
         next_s.slew      = csd_pkg::RST_SLEW;
         next_s.pull_inh2 = csd_pkg::RST_PULL_INH2;
         next_s.strap_sel = clock_select_pin;
         next_s.boot_code = boot_freq_code;
         next_s.osc_en    = !clock_select_pin;
         next_s.ldo_en    = !clock_select_pin;
      end
   end

   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   // ==========================================================
   // Bus handshakes
   assign awready = !s.aw_hold && !s.b_valid;
   assign wready  = !s.w_hold && !s.b_valid;
   assign bvalid  = s.b_valid;
   assign bresp   = s.b_resp;
   assign arready = !s.r_valid;
   assign rvalid  = s.r_valid;
   assign rdata   = s.r_data;
   assign rresp   = s.r_resp;

   // ==========================================================
   // Clock source outputs
   // The strap copy only changes under reset, so a board that misbehaves
   // cannot swap the system clock mid-run.
   assign sys_clock_from_ext    = s.strap_sel;
   assign ext_clock_gate_en     = s.strap_sel;
   assign ext_clock_pulldown_en = !s.pull_inh2[csd_pkg::EXT_PD_INH_BIT];
   assign usb_oscillator_enable = s.osc_en;
   assign usb_regulator_enable  = s.ldo_en;
   assign boot_assumed_freq     = s.boot_code;

   // ==========================================================
   // Debug clock pin
   assign dbg_ctl.source_sel = s.dbg_cfg[csd_pkg::SRC_LSB +: csd_pkg::SRC_W];
   assign dbg_ctl.drive_en   = !s.cpu_st3[csd_pkg::DBG_OFF_BIT];
   assign dbg_ctl.slow_slew  = s.slew[csd_pkg::SLEW_BIT];

   csd_dbg_drv u_drv (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .cfg             (dbg_ctl),
      .gen_clocks      (gen_clocks),
      .pin_out         (debug_clock_pin_out),
      .pin_oe_n        (debug_clock_pin_oe_n),
      .pin_pulldown_en (debug_clock_pin_pulldown_en),
      .pin_slow_slew   (debug_clock_pin_slow_slew)
   );

endmodule : csd_clock_ctrl

// ### testbench/csd_clock_ctrl_sva.sv
// Checker for the clock source and debug clock output block.
// Assumes it is bound to csd_clock_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module csd_clock_ctrl_sva (
   // Clock, reset and write response
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       bvalid,
   // Clock source and pin outputs
   input wire logic       sys_clock_from_ext,
   input wire logic       ext_clock_gate_en,
   input wire logic       ext_clock_pulldown_en,
   input wire logic       usb_oscillator_enable,
   input wire logic       usb_regulator_enable,
   input wire logic [2:0] boot_assumed_freq,
   input wire logic       debug_clock_pin_oe_n,
   input wire logic       debug_clock_pin_pulldown_en
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ==========
   // Pin driver
   a_pulldown_tracks_oe: assert property (
      debug_clock_pin_pulldown_en == debug_clock_pin_oe_n)
      else $error("pulldown does not follow the driver state");
   a_drive_after_reset: assert property ($rose(aresetn) |-> !debug_clock_pin_oe_n)
      else $error("debug clock not driven after reset");
   // A register write is the only cause allowed to move the driver state.
   a_oe_needs_write: assert property (
      $changed(debug_clock_pin_oe_n) |-> bvalid || $past(bvalid))
      else $error("driver state changed without a write");

   // ==========
   // Clock source
   a_usb_forced_on: assert property (
      !sys_clock_from_ext |-> usb_oscillator_enable && usb_regulator_enable)
      else $error("oscillator or regulator off with internal source");
   a_usb_reset_off: assert property ($rose(aresetn) && sys_clock_from_ext
      |-> !usb_oscillator_enable && !usb_regulator_enable)
      else $error("oscillator or regulator on after reset with external source");
   a_gate_follows_sel: assert property (ext_clock_gate_en == sys_clock_from_ext)
      else $error("external clock gate disagrees with source");
   a_strap_held: assert property (
      $past(aresetn) |-> $stable(sys_clock_from_ext) && $stable(boot_assumed_freq))
      else $error("strap value moved outside reset");
   a_ext_pd_reset: assert property ($rose(aresetn) |-> !ext_clock_pulldown_en)
      else $error("external clock pulldown on after reset");
   a_ext_pd_write: assert property (
      $changed(ext_clock_pulldown_en) |-> bvalid || $past(bvalid))
      else $error("external clock pulldown changed without a write");
endmodule : csd_clock_ctrl_sva

// ### testbench/csd_board.sv
// Board model: strap pins and the external clock input.
// Assumes the bench requests a strap level only while reset is low.
`timescale 1ns/1ps
module csd_board (
   // Clock, reset and bench requests
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       sel_req,
   input  wire logic [2:0] code_req,
   input  wire logic       misstrap,
   // Straps and external clock
   output logic            clock_select_pin,
   output logic [2:0]      boot_freq_code,
   output logic            ext_clock
);
   logic       sel_q;
   logic [2:0] code_q;
   // Straps are fixed at reset; misstrap breaks that only when a scenario asks.
   always @(posedge aclk) begin
      if (!aresetn) begin
         sel_q  <= sel_req;
         code_q <= code_req;
      end
   end
   assign clock_select_pin = aresetn ? sel_q ^ misstrap : sel_req;
   assign boot_freq_code   = aresetn ? code_q ^ {3{misstrap}} : code_req;
   assign ext_clock        = sel_q & aclk;
endmodule : csd_board

// ### testbench/tb_top.sv
// Self-checking bench for the clock source and debug clock output block.
// Assumes the design package is compiled first; bready and rready stay high.
`timescale 1ns/1ps
module tb_top;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
   logic        arvalid = 0, rready = 1, sel_req = 0, misstrap = 0;
   logic        awready, wready, bvalid, arready, rvalid, clock_select_pin;
   logic        sys_clock_from_ext, ext_clock_gate_en, ext_clock_pulldown_en;
   logic        usb_oscillator_enable, usb_regulator_enable, debug_clock_pin_out;
   logic        debug_clock_pin_oe_n, debug_clock_pin_pulldown_en, debug_clock_pin_slow_slew;
   logic [15:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, seed = 32'h000151D3;
   logic [1:0]  bresp, rresp;
   logic [2:0]  awprot = '0, arprot = '0, code_req = '0, boot_freq_code, boot_assumed_freq;
   logic [3:0]  wstrb = 4'hF, gen_clocks = '0, g_prev = '0;
   logic [15:0] m [int];
   int          miscompares = 0, num_checks = 0;

   always #12.5 aclk = ~aclk;

   csd_clock_ctrl u_csd_clock_ctrl (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .clock_select_pin, .boot_freq_code,
      .gen_clocks, .sys_clock_from_ext, .ext_clock_gate_en, .ext_clock_pulldown_en,
      .usb_oscillator_enable, .usb_regulator_enable, .boot_assumed_freq, .debug_clock_pin_out,
      .debug_clock_pin_oe_n, .debug_clock_pin_pulldown_en, .debug_clock_pin_slow_slew);
   csd_board u_csd_board (.aclk, .aresetn, .sel_req, .code_req, .misstrap,
      .clock_select_pin, .boot_freq_code, .ext_clock());

   // ==========
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Generator taps change randomly every cycle so a wrong tap shows quickly.
   always @(posedge aclk) begin
      g_prev     <= gen_clocks;
      gen_clocks <= 4'(xs());
   end

   task automatic print_verdict();
      if (miscompares == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   // Ready is looked at on the falling edge, so the handshake edge is known before it lands.
   task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      logic da, dw, b;
      logic [1:0] r;
      int n;
      da = 0;
      dw = 0;
      b = 0;
      n = 0;
      r = '0;
      // Start just after a rising edge even when the caller last waited on a falling one.
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1;
      wvalid  <= 1;
      while (!(da && dw) && n < 99) begin
         @(negedge aclk);
         da |= awready;
         dw |= wready;
         @(posedge aclk);
         if (da) awvalid <= 0;
         if (dw) wvalid <= 0;
         n++;
      end
      while (!b && n < 99) begin
         @(negedge aclk);
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         n++;
      end
      if (n >= 99) begin
         miscompares++;
         print_verdict();
      end
      chk(r, er);
   endtask : axw

   task automatic axr(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic g;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      g = 0;
      n = 0;
      d = '0;
      r = '0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1;
      while (!g && n < 99) begin
         @(negedge aclk);
         g = arready;
         @(posedge aclk);
         n++;
      end
      arvalid <= 0;
      g = 0;
      while (!g && n < 99) begin
         @(negedge aclk);
         g = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         n++;
      end
      if (n >= 99) begin
         miscompares++;
         print_verdict();
      end
      chk(d, ed);
      chk(r, er);
   endtask : axr

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      axw(a, {16'h0, d}, csd_pkg::RESP_OKAY);
      m[a] = d;
   endtask : wr

   task automatic pin_chk(input int src);
      repeat (6) begin
         @(negedge aclk);
         chk(debug_clock_pin_out, g_prev[src]);
      end
   endtask : pin_chk

   task automatic do_reset(input logic s, input logic [2:0] c);
      aresetn <= 0; sel_req <= s; code_req <= c;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      m[csd_pkg::ADDR_DBG_CFG]    = csd_pkg::RST_DBG_CFG;
      m[csd_pkg::ADDR_CPU_ST3]    = csd_pkg::RST_CPU_ST3;
      m[csd_pkg::ADDR_SLEW]       = csd_pkg::RST_SLEW;
      m[csd_pkg::ADDR_PULL_INH2]  = csd_pkg::RST_PULL_INH2;
      @(negedge aclk);
      chk({sys_clock_from_ext, ext_clock_gate_en}, {s, s});
      chk({usb_oscillator_enable, usb_regulator_enable}, {!s, !s});
      chk({debug_clock_pin_oe_n, debug_clock_pin_pulldown_en}, 2'h0);
      chk(ext_clock_pulldown_en, 0);
      chk(boot_assumed_freq, c);
      @(posedge aclk);
      foreach (m[a]) axr(16'(a), m[a], csd_pkg::RESP_OKAY);
      axr(csd_pkg::ADDR_CLK_STATUS, {26'h0, c, !s, !s, s}, csd_pkg::RESP_OKAY);
   endtask : do_reset

   // ==========
   // Scenarios
   initial begin
      do_reset(0, 3'h5);
      axw(csd_pkg::ADDR_USB_CTRL, 32'h0, csd_pkg::RESP_OKAY);
      axr(csd_pkg::ADDR_CLK_STATUS, {26'h0, 3'h5, 3'h6}, csd_pkg::RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
         wr(csd_pkg::ADDR_DBG_CFG, 16'(s));
         pin_chk(s);
      end
      wr(csd_pkg::ADDR_CPU_ST3, 16'h0004);
      @(negedge aclk);
      chk({debug_clock_pin_oe_n, debug_clock_pin_pulldown_en}, 2'h3);
      wr(csd_pkg::ADDR_CPU_ST3, 16'h0000);
      @(negedge aclk);
      chk({debug_clock_pin_oe_n, debug_clock_pin_pulldown_en}, 2'h0);
      pin_chk(3);
      wr(csd_pkg::ADDR_SLEW, 16'h0001);
      wr(csd_pkg::ADDR_PULL_INH2, 16'h0000);
      @(negedge aclk);
      chk({debug_clock_pin_slow_slew, ext_clock_pulldown_en}, 2'h3);
      wr(csd_pkg::ADDR_PULL_INH2, 16'h0001);
      @(negedge aclk);
      chk(ext_clock_pulldown_en, 0);
      // Only the low byte lane is enabled, so the high byte must keep its old value.
      @(posedge aclk);
      wstrb <= 4'h1;
      axw(csd_pkg::ADDR_DBG_CFG, 32'h0000_AB02, csd_pkg::RESP_OKAY);
      wstrb <= 4'hF;
      m[csd_pkg::ADDR_DBG_CFG] = 16'h0002;
      pin_chk(2);
      axw(16'h7010, 32'h1, csd_pkg::RESP_SLVERR);
      axr(16'h7010, 32'h0, csd_pkg::RESP_SLVERR);
      foreach (m[a]) axr(16'(a), m[a], csd_pkg::RESP_OKAY);
      do_reset(1, 3'h2);
      axw(csd_pkg::ADDR_USB_CTRL, 32'h3, csd_pkg::RESP_OKAY);
      @(negedge aclk);
      chk({usb_oscillator_enable, usb_regulator_enable}, 2'h3);
      @(posedge aclk);
      misstrap <= 1;
      repeat (4) @(negedge aclk);
      chk({sys_clock_from_ext, boot_assumed_freq}, 4'hA);
      print_verdict();
   end
endmodule : tb_top

bind csd_clock_ctrl csd_clock_ctrl_sva u_csd_clock_ctrl_sva (.aclk, .aresetn, .bvalid,
   .sys_clock_from_ext, .ext_clock_gate_en, .ext_clock_pulldown_en, .usb_oscillator_enable,
   .usb_regulator_enable, .boot_assumed_freq, .debug_clock_pin_oe_n,
   .debug_clock_pin_pulldown_en);
